// ==== logic/hcg_hop_channel_generator.sv ====
// Hop channel generator for four regional hopping plans
`timescale 1ns/1ns

// Behaviour
// R1 - Israel basic table, 35 entries, 21..55
// R2 - Israel adds offset, wraps by 35 above 55
// R3 - Israel set 1-3, sequence 1-11, index 1-35
// R4 - Frequency equals 2400 plus channel
// R5 - Japan has 23 hops within 73..95
// R6 - Step is 6 plus offset for Japan, Korea
// R7 - Japan channel is product mod 23 plus 73
// R8 - Korea channel is product mod 23 plus 30
// R9 - Japan, Korea set 1-3, sequence 1-4, index 1-23
// R10 - Spain basic table, 27 entries, 47..73
// R11 - Spain adds offset, wraps by 27 above 73
// R12 - Spain set 1-3, sequence 1-9
// R13 - Set 1 sequence 1 gives basic table
// R14 - Tick advances index, wraps, reset gives 1
// R15 - Israel entry 18 is a parameter
module hcg_hop_channel_generator
    import hcg_pkg::*;
#(
    parameter logic [6:0] ISR_ENTRY18 = HCG_ISR_UNK_DEFAULT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Plan selection
    input  wire logic [1:0]  region,
    input  wire logic [1:0]  hopSet,
    input  wire logic [3:0]  hopSeq,
    // Hop timing
    input  wire logic        hopTick,
    // Hop result
    output logic      [5:0]  hopIndex,
    output logic      [6:0]  channel,
    output logic      [11:0] freqMhz,
    output logic             chanValid
);

    typedef struct packed {
        logic [5:0]  idx;
        logic [6:0]  chan;
        logic [11:0] freq;
        logic        valid;
    } hcg_state_t;

    hcg_state_t s;
    hcg_state_t next_s;

    function automatic int planLen(input logic [1:0] rg);
        case (rg)
            HCG_ISRAEL: planLen = HCG_ISR_LEN;
            HCG_SPAIN:  planLen = HCG_SPN_LEN;
            default:    planLen = HCG_CALC_LEN; // R5
        endcase
    endfunction

    function automatic logic [6:0] offsetOf(input logic [1:0] hs,
                                            input logic [3:0] hq);
        offsetOf = 7'((int'(hs) - 1) * HCG_SET_STRIDE + int'(hq) - 1);
    endfunction

    function automatic logic [6:0] isrBase(input logic [5:0] ix);
        isrBase = 7'h00;
        if (int'(ix) == HCG_ISR_UNK) begin
            isrBase = ISR_ENTRY18; // R15
        end else if (ix >= 6'h01 && int'(ix) <= HCG_ISR_LEN) begin
            isrBase = HCG_ISR_BASE[ix]; // R1
        end
    endfunction

    function automatic logic [6:0] spnBase(input logic [5:0] ix);
        spnBase = 7'h00;
        if (ix >= 6'h01 && int'(ix) <= HCG_SPN_LEN) begin
            spnBase = HCG_SPN_BASE[ix]; // R10
        end
    endfunction

    // Bit 7 is the validity of the selection, bits 6:0 the channel
    function automatic logic [7:0] calcChan(input logic [1:0] rg,
                                            input logic [1:0] hs,
                                            input logic [3:0] hq,
                                            input logic [5:0] ix);
        logic [6:0] off;
        logic [7:0] sum;
        logic [6:0] step;
        logic [9:0] prod;
        logic [6:0] rem;
        logic       vld;
        logic [6:0] ch;
        off  = offsetOf(hs, hq);
        step = 7'(HCG_STEP_BASE + int'(off)); // R6
        prod = 10'((int'(ix) - 1) * int'(step));
        rem  = 7'(int'(prod) % HCG_CALC_LEN);
        vld  = hs >= 2'h1 && int'(hs) <= HCG_SET_MAX && hq >= 4'h1
               && ix >= 6'h01 && int'(ix) <= planLen(rg);
        sum  = 8'h00;
        ch   = HCG_CHAN_RESET;
        case (rg)
            HCG_ISRAEL: begin
                vld = vld && int'(hq) <= HCG_ISR_SEQ_MAX; // R3
                sum = {1'b0, isrBase(ix)} + {1'b0, off}; // R2 R13
                if (sum > {1'b0, HCG_ISR_HIGH}) begin
                    sum = sum - 8'(HCG_ISR_LEN); // R2
                end
                ch = sum[6:0];
            end
            HCG_JAPAN: begin
                vld = vld && int'(hq) <= HCG_CALC_SEQ_MAX; // R9
                ch  = rem + HCG_JPN_LOW; // R7
            end
            HCG_KOREA: begin
                vld = vld && int'(hq) <= HCG_CALC_SEQ_MAX; // R9
                ch  = rem + HCG_KOR_LOW; // R8
            end
            HCG_SPAIN: begin
                vld = vld && int'(hq) <= HCG_SPN_SEQ_MAX; // R12
                sum = {1'b0, spnBase(ix)} + {1'b0, off}; // R11 R13
                if (sum > {1'b0, HCG_SPN_HIGH}) begin
                    sum = sum - 8'(HCG_SPN_LEN); // R11
                end
                ch = sum[6:0];
            end
            default: begin
                vld = 1'b0;
            end
        endcase
        // An invalid selection shows channel 0 rather than a stray value
        calcChan = vld ? {1'b1, ch} : {1'b0, HCG_CHAN_RESET};
    endfunction

    logic [7:0] nextCalc;

    always_comb begin
        next_s = s;
        if (hopTick) begin
            // A region change may leave the index past the end
            if (int'(s.idx) >= planLen(region)) begin
                next_s.idx = HCG_IDX_RESET; // R14
            end else begin
                next_s.idx = s.idx + 6'h01; // R14
            end
        end
        // Channel follows the index it is shown with, same edge
        nextCalc     = calcChan(region, hopSet, hopSeq, next_s.idx);
        next_s.valid = nextCalc[7];
        next_s.chan  = nextCalc[6:0];
        next_s.freq  = HCG_FREQ_BASE + {5'h00, nextCalc[6:0]}; // R4
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s.idx   <= HCG_IDX_RESET; // R14
            s.chan  <= HCG_CHAN_RESET;
            s.freq  <= HCG_FREQ_RESET;
            s.valid <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign hopIndex  = s.idx;
    assign channel   = s.chan;
    assign freqMhz   = s.freq;
    assign chanValid = s.valid;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_isr_range;
        chanValid && $past(region) == HCG_ISRAEL
            |-> channel >= 7'h15 && channel <= 7'h37;
    endproperty
    a_isr_range: assert property (p_isr_range) // R1
        else $error("Israel channel out of range");

    property p_isr_wrap;
        chanValid && $past(region) == HCG_ISRAEL
            |-> (channel == isrBase(hopIndex)
                            + offsetOf($past(hopSet), $past(hopSeq)))
             || (channel + 7'd35 == isrBase(hopIndex)
                            + offsetOf($past(hopSet), $past(hopSeq)));
    endproperty
    a_isr_wrap: assert property (p_isr_wrap) // R2
        else $error("Israel channel not basic plus offset");

    property p_isr_seq_bad;
        region == HCG_ISRAEL && hopSeq > 4'hB |=> !chanValid;
    endproperty
    a_isr_seq_bad: assert property (p_isr_seq_bad) // R3
        else $error("Israel sequence above 11 accepted");

    property p_freq;
        // Reset shows zero, still visible at the first edge after release
        $past(arst_n) |-> freqMhz == 12'd2400 + {5'h00, channel};
    endproperty
    a_freq: assert property (p_freq) // R4
        else $error("Frequency not 2400 plus channel");

    property p_jpn_range;
        chanValid && $past(region) == HCG_JAPAN
            |-> channel >= 7'd73 && channel <= 7'd95 && hopIndex <= 6'd23;
    endproperty
    a_jpn_range: assert property (p_jpn_range) // R5
        else $error("Japan channel or index out of range");

    property p_jpn_first;
        chanValid && $past(region) == HCG_JAPAN && hopIndex == 6'd1
            |-> channel == 7'd73;
    endproperty
    a_jpn_first: assert property (p_jpn_first) // R7
        else $error("Japan first hop is not channel 73");

    property p_kor_step;
        chanValid && $past(region) == HCG_KOREA && hopIndex == 6'd2
            |-> channel == 7'd30
                + 7'(6 + int'(offsetOf($past(hopSet), $past(hopSeq))));
    endproperty
    a_kor_step: assert property (p_kor_step) // R8
        else $error("Korea second hop does not equal 30 plus step");

    property p_spn_range;
        chanValid && $past(region) == HCG_SPAIN
            |-> channel >= 7'd47 && channel <= 7'd73;
    endproperty
    a_spn_range: assert property (p_spn_range) // R10
        else $error("Spain channel out of range");

    property p_basic;
        chanValid && $past(region) == HCG_SPAIN && $past(hopSet) == 2'h1
            && $past(hopSeq) == 4'h1 |-> channel == spnBase(hopIndex);
    endproperty
    a_basic: assert property (p_basic) // R13
        else $error("Basic selection not equal to stored table");

    property p_wrap_index;
        hopTick && int'(hopIndex) >= planLen(region) |=> hopIndex == 6'd1;
    endproperty
    a_wrap_index: assert property (p_wrap_index) // R14
        else $error("Index did not return to 1 after last hop");

    property p_hold_index;
        !hopTick |=> hopIndex == $past(hopIndex);
    endproperty
    a_hold_index: assert property (p_hold_index) // R14
        else $error("Index moved without a hop tick");

    property p_spn_wrap;
        chanValid && $past(region) == HCG_SPAIN
            |-> (channel == spnBase(hopIndex)
                            + offsetOf($past(hopSet), $past(hopSeq)))
             || (channel + 7'(HCG_SPN_LEN) == spnBase(hopIndex)
                            + offsetOf($past(hopSet), $past(hopSeq)));
    endproperty
    a_spn_wrap: assert property (p_spn_wrap) // R11
        else $error("Spain channel not basic plus offset");

    property p_kor_range;
        chanValid && $past(region) == HCG_KOREA
            |-> channel >= HCG_KOR_LOW && channel <= HCG_KOR_HIGH;
    endproperty
    a_kor_range: assert property (p_kor_range) // R8
        else $error("Korea channel out of range");

    property p_jpn_step;
        chanValid && $past(region) == HCG_JAPAN && hopIndex == 6'h02
            |-> channel == HCG_JPN_LOW + 7'(HCG_STEP_BASE
                + int'(offsetOf($past(hopSet), $past(hopSeq))));
    endproperty
    a_jpn_step: assert property (p_jpn_step) // R6
        else $error("Japan second hop does not equal 73 plus step");

    property p_calc_seq_bad;
        (region == HCG_JAPAN || region == HCG_KOREA) && hopSeq > 4'h4
            |=> !chanValid;
    endproperty
    a_calc_seq_bad: assert property (p_calc_seq_bad) // R9
        else $error("Computed plan sequence above 4 accepted");

    property p_spn_seq_bad;
        region == HCG_SPAIN && hopSeq > 4'h9 |=> !chanValid;
    endproperty
    a_spn_seq_bad: assert property (p_spn_seq_bad) // R12
        else $error("Spain sequence above 9 accepted");

    property p_set_bad;
        hopSet == 2'h0 |=> !chanValid;
    endproperty
    a_set_bad: assert property (p_set_bad) // R3
        else $error("Hopping set 0 accepted");

    property p_entry18;
        chanValid && $past(region) == HCG_ISRAEL && hopIndex == 6'h12
            && $past(hopSet) == 2'h1 && $past(hopSeq) == 4'h1
            |-> channel == ISR_ENTRY18;
    endproperty
    a_entry18: assert property (p_entry18) // R15
        else $error("Israel entry 18 not the configured value");

    property p_isr_basic;
        chanValid && $past(region) == HCG_ISRAEL && $past(hopSet) == 2'h1
            && $past(hopSeq) == 4'h1 |-> channel == isrBase(hopIndex);
    endproperty
    a_isr_basic: assert property (p_isr_basic) // R13
        else $error("Israel basic selection not equal to stored table");

    c_isr_wrap: cover property (chanValid && $past(region) == HCG_ISRAEL
                                && channel < isrBase(hopIndex));
    c_jpn_last: cover property (chanValid && $past(region) == HCG_JAPAN
                                && hopIndex == 6'd23);
    c_spn_wrap: cover property (hopTick && region == HCG_SPAIN
                                && hopIndex == 6'd27);
    c_korea: cover property (chanValid && $past(region) == HCG_KOREA);

endmodule

// ==== inc/hcg_pkg.sv ====
// Constants and basic sequences for the hop channel generator
package hcg_pkg;

    // Region codes on the region port
    localparam logic [1:0] HCG_ISRAEL = 2'h0;
    localparam logic [1:0] HCG_JAPAN  = 2'h1;
    localparam logic [1:0] HCG_KOREA  = 2'h2;
    localparam logic [1:0] HCG_SPAIN  = 2'h3;

    // Frequency base, MHz
    localparam logic [11:0] HCG_FREQ_BASE = 12'h960;

    // Selection ranges
    localparam int HCG_SET_MAX     = 3;
    localparam int HCG_SET_STRIDE  = 3;
    localparam int HCG_ISR_SEQ_MAX = 11;
    localparam int HCG_CALC_SEQ_MAX = 4;
    localparam int HCG_SPN_SEQ_MAX = 9;

    // Israel plan
    localparam int          HCG_ISR_LEN  = 35;
    localparam logic [6:0]  HCG_ISR_LOW  = 7'h15;
    localparam logic [6:0]  HCG_ISR_HIGH = 7'h37;
    localparam int          HCG_ISR_UNK  = 18;
    localparam logic [6:0]  HCG_ISR_UNK_DEFAULT = 7'h1B;
    localparam logic [6:0] HCG_ISR_BASE [1:35] = '{
        7'h26, 7'h1A, 7'h27, 7'h35, 7'h2C, 7'h1C, 7'h25, 7'h19, 7'h22,
        7'h36, 7'h2F, 7'h1F, 7'h34, 7'h29, 7'h32, 7'h2B, 7'h21, 7'h00,
        7'h31, 7'h23, 7'h2E, 7'h15, 7'h1D, 7'h16, 7'h24, 7'h18, 7'h20,
        7'h33, 7'h2D, 7'h1E, 7'h30, 7'h28, 7'h17, 7'h2A, 7'h37};

    // Spain plan
    localparam int          HCG_SPN_LEN  = 27;
    localparam logic [6:0]  HCG_SPN_LOW  = 7'h2F;
    localparam logic [6:0]  HCG_SPN_HIGH = 7'h49;
    localparam logic [6:0] HCG_SPN_BASE [1:27] = '{
        7'h3C, 7'h33, 7'h47, 7'h41, 7'h34, 7'h3B, 7'h32, 7'h39, 7'h48,
        7'h42, 7'h37, 7'h46, 7'h3E, 7'h45, 7'h38, 7'h44, 7'h2F, 7'h35,
        7'h3D, 7'h30, 7'h43, 7'h36, 7'h3F, 7'h31, 7'h3A, 7'h40, 7'h49};

    // Japan and Korea plans
    localparam int          HCG_CALC_LEN = 23;
    localparam int          HCG_STEP_BASE = 6;
    localparam logic [6:0]  HCG_JPN_LOW  = 7'h49;
    localparam logic [6:0]  HCG_JPN_HIGH = 7'h5F;
    localparam logic [6:0]  HCG_KOR_LOW  = 7'h1E;
    localparam logic [6:0]  HCG_KOR_HIGH = 7'h34;

    // Reset values
    localparam logic [5:0]  HCG_IDX_RESET  = 6'h01;
    localparam logic [6:0]  HCG_CHAN_RESET = 7'h00;
    localparam logic [11:0] HCG_FREQ_RESET = 12'h000;

endpackage

// ==== verif/hcg_hop_timer.sv ====
// Hop timing model that issues hop ticks on request
`timescale 1ns/1ns
module hcg_hop_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Request side, a held request gives a tick every lag+1 cycles
    input  wire logic       stepReq,
    input  wire logic [3:0] lag,
    // Tick to the generator
    output logic            hopTick
);
    logic       pend;
    logic [3:0] cnt;

    // Falling edge keeps the tick clear of the sampling edge
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hopTick <= 1'b0;
            pend    <= 1'b0;
            cnt     <= 4'h0;
        end else begin
            hopTick <= 1'b0;
            if (pend && cnt == 4'h0) begin
                hopTick <= 1'b1;
                pend    <= stepReq;
                cnt     <= lag;
            end else if (pend) begin
                cnt <= cnt - 4'h1;
            end else if (stepReq) begin
                pend <= 1'b1;
                cnt  <= lag;
            end
        end
    end
endmodule

// ==== verif/hcg_hop_channel_generator_tb_top.sv ====
// Self-checking bench for the hop channel generator
`timescale 1ns/1ns
module hcg_hop_channel_generator_tb_top
    import hcg_pkg::*;
;
    // Unconfirmed table entry, value arbitrary
    localparam logic [6:0] ENTRY18 = 7'h1B;
    logic        clk;
    logic        arst_n;
    logic [1:0]  region;
    logic [1:0]  hopSet;
    logic [3:0]  hopSeq;
    logic        hopTick;
    logic        stepReq;
    logic [3:0]  lag;
    logic [5:0]  hopIndex;
    logic [6:0]  channel;
    logic [11:0] freqMhz;
    logic        chanValid;
    logic [5:0]  expIdx;
    int          mismatches;
    int          total_checks;
    int          cycles;

    hcg_hop_channel_generator #(.ISR_ENTRY18(ENTRY18)) uut (
        .clk(clk), .arst_n(arst_n), .region(region), .hopSet(hopSet),
        .hopSeq(hopSeq), .hopTick(hopTick), .hopIndex(hopIndex),
        .channel(channel), .freqMhz(freqMhz), .chanValid(chanValid));
    hcg_hop_timer timer (
        .clk(clk), .arst_n(arst_n), .stepReq(stepReq), .lag(lag),
        .hopTick(hopTick));

    function automatic int plan_len(input logic [1:0] r);
        return (r == HCG_ISRAEL) ? 35 : (r == HCG_SPAIN) ? 27 : 23;
    endfunction

    // Returns valid flag over channel
    function automatic logic [7:0] exp_chan(input logic [1:0] r,
        input logic [1:0] s, input logic [3:0] h, input logic [5:0] i);
        int hmax;
        int off;
        int c;
        hmax = (r == HCG_ISRAEL) ? 11 : (r == HCG_SPAIN) ? 9 : 4;
        off = (int'(s) - 1) * 3 + (int'(h) - 1);
        if (s < 1 || s > 3 || h < 1 || h > hmax || i < 1 || i > plan_len(r))
            return 8'h00;
        case (r)
            HCG_ISRAEL: begin
                c = ((i == 18) ? ENTRY18 : HCG_ISR_BASE[i]) + off;
                c = (c > 55) ? c - 35 : c;
            end
            HCG_SPAIN: begin
                c = HCG_SPN_BASE[i] + off;
                c = (c > 73) ? c - 27 : c;
            end
            HCG_JAPAN: c = ((int'(i) - 1) * (6 + off)) % 23 + 73;
            default:   c = ((int'(i) - 1) * (6 + off)) % 23 + 30;
        endcase
        return {1'b1, 7'(c)};
    endfunction

    // Index model follows the ticks the generator samples
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            expIdx <= 6'h01;
        else if (hopTick)
            expIdx <= (expIdx >= plan_len(region)) ? 6'h01 : expIdx + 6'h01;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %0d want %0d", $time, what,
                got, exp);
        end
    endtask

    task automatic check_now;
        logic [7:0] e;
        e = exp_chan(region, hopSet, hopSeq, expIdx);
        chk(12'(hopIndex), 12'(expIdx), "index");
        chk(12'(chanValid), 12'(e[7]), "valid");
        chk(12'(channel), 12'(e[6:0]), "channel");
        chk(freqMhz, 12'h960 + 12'(e[6:0]), "freq");
    endtask

    // Called at a falling edge; checks every cycle for n cycles
    task automatic run(input logic [1:0] r, input logic [1:0] s,
        input logic [3:0] h, input int n, input logic [3:0] lg,
        input logic go);
        region = r;
        hopSet = s;
        hopSeq = h;
        lag <= lg;
        stepReq <= go;
        repeat (n) begin
            @(negedge clk);
            check_now();
        end
    endtask

    task automatic t_reset;
        repeat (4) @(negedge clk);
        chk(12'(hopIndex), 12'h001, "reset index");
        chk(12'(channel) + freqMhz + 12'(chanValid), 12'h000, "reset");
        arst_n = 1'b1;
    endtask

    task automatic t_calc;
        run(HCG_JAPAN, 2'h3, 4'h1, 30, 4'h0, 1'b1);
        for (int s = 1; s <= 3; s++)
            for (int h = 1; h <= 4; h++)
                run(HCG_KOREA, 2'(s), 4'(h), 24, 4'h0, 1'b1);
    endtask

    task automatic t_tables;
        run(HCG_ISRAEL, 2'h1, 4'h1, 36, 4'h0, 1'b1);
        run(HCG_ISRAEL, 2'h3, 4'hB, 36, 4'h0, 1'b1);
        run(HCG_SPAIN, 2'h1, 4'h1, 28, 4'h0, 1'b1);
        run(HCG_SPAIN, 2'h3, 4'h9, 28, 4'h0, 1'b1);
        run(HCG_SPAIN, 2'h2, 4'h5, 60, 4'h5, 1'b1);
    endtask

    // Bad selections and an index left beyond the new plan length
    task automatic t_refuse;
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        run(HCG_ISRAEL, 2'h0, 4'h1, 29, 4'h0, 1'b1);
        run(HCG_JAPAN, 2'h1, 4'h5, 4, 4'h0, 1'b0);
        run(HCG_JAPAN, 2'h1, 4'h4, 4, 4'h0, 1'b0);
        run(HCG_SPAIN, 2'h1, 4'hA, 3, 4'h0, 1'b1);
        run(HCG_ISRAEL, 2'h1, 4'hC, 3, 4'h0, 1'b1);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Whole run is near 550 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        arst_n = 1'b0;
        region = HCG_ISRAEL;
        hopSet = 2'h1;
        hopSeq = 4'h1;
        stepReq = 1'b0;
        lag = 4'h0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        t_reset();
        t_calc();
        t_tables();
        t_refuse();
        close_out();
    end
endmodule
